// ===== rtl/cwpd_defs.svh
// Offsets, field positions, reset values and codes of the config word decoder
`ifndef CWPD_DEFS_SVH
`define CWPD_DEFS_SVH
// APB byte addresses
`define CWPD_OFF_WDT_CFG   8'h00
`define CWPD_OFF_MEM_CFG   8'h04
`define CWPD_OFF_CODE_CFG  8'h08
`define CWPD_OFF_CTRL      8'h0C
`define CWPD_OFF_STATUS    8'h10
`define CWPD_OFF_UID0      8'h14
`define CWPD_OFF_UID3      8'h20
// Erased config word value
`define CWPD_ERASED        14'h3FFF
// Bits that read back as one
`define CWPD_WDT_ONES      14'h0080
`define CWPD_MEM_ONES      14'h1460
`define CWPD_CODE_ONES     14'h3FFE
// Protection bits that may only be cleared
`define CWPD_MEM_STICKY    14'h0B98
// Field positions
`define CWPD_MODE_HI       6
`define CWPD_MODE_LO       5
`define CWPD_PER_HI        4
`define CWPD_LOWV_BIT      13
`define CWPD_SFWP_BIT      11
`define CWPD_CFGWP_BIT     9
`define CWPD_BOOTWP_BIT    8
`define CWPD_APPWP_BIT     7
`define CWPD_SFEN_BIT      4
`define CWPD_BOOTEN_BIT    3
`define CWPD_CODEP_BIT     0
// Period codes
`define CWPD_PER_ERASED    5'h1F
`define CWPD_PER_DEFAULT   5'h0B
`define CWPD_PER_MAX       5'h12
`define CWPD_PER_ALT32     5'h13
`define CWPD_PER_BIAS      5'h05
// Boot block sizes in words
`define CWPD_BB_512        16'h0200
`define CWPD_BB_1024       16'h0400
`define CWPD_BB_2048       16'h0800
// Configuration word address range
`define CWPD_CFG_LO        16'h8007
`define CWPD_CFG_HI        16'h800B
`endif

// ===== rtl/cwpd_pkg.sv
// Types shared by the config word decoder
package cwpd_pkg;
  // Watchdog operating mode, in field code order
  typedef enum logic [1:0] {
    CWPD_WDT_OFF,
    CWPD_WDT_SOFT,
    CWPD_WDT_AWAKE,
    CWPD_WDT_ON
  } cwpd_mode_e;
endpackage : cwpd_pkg

// ===== rtl/cwpd_top.sv
// Configuration word protection and watchdog decode with APB access
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "cwpd_defs.svh"

// Contract
// - Mode field selects watchdog on, awake, software, off
// - Erased period loads divide 65536, software-changeable
// - Codes up to 10010 fix period two-power plus five
// - Low-voltage bit forces reset pin as master clear
// - Low-voltage bit cannot clear during low-voltage programming
// - Storage flash protect blocks self-writes when enabled
// - Config protect blocks self-writes to config words
// - Boot protect blocks self-writes when boot enabled
// - Application protect blocks self-writes to application
// - Storage flash and boot enables are active low
// - Boot size writable only while boot disabled
// - Boot size decode, clamped to half memory
// - Protection bits sticky until bulk erase
// - Code protect blocks external access, reads zero
// - CPU reads always pass
// - Self-writes allowed per region protect bits
// - Unimplemented config bits read as one
// - Four user ID words readable and writable
module cwpd_top #(
  parameter int PM_WORDS     = 8192,
  parameter int SFLASH_WORDS = 128
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic [31:0]      PRDATA,
  // Programming and power state
  input  wire logic        LOWV_PROG_ACTIVE,
  input  wire logic        BULK_ERASE,
  input  wire logic        SLEEP,
  input  wire logic        MCLR_ENABLE_CFG,
  // Watchdog and reset pin
  output logic             WDT_ENABLE,
  output logic [4:0]       WDT_DIV_EXP,
  output logic             WDT_CFG_ERROR,
  output logic             MCLR_PIN_IS_RESET,
  // Self-write check
  input  wire logic        SELF_WR_REQ,
  input  wire logic [15:0] SELF_WR_ADDR,
  output logic             SELF_WR_OK,
  output logic [15:0]      BOOT_BLOCK_WORDS,
  // Program memory read paths
  input  wire logic [13:0] PM_RD_DATA,
  output logic [13:0]      CPU_RD_DATA,
  output logic [13:0]      EXT_RD_DATA,
  output logic             EXT_ACCESS_BLOCK
);

  logic [13:0] wdt_word;
  logic [13:0] mem_word;
  logic [13:0] code_word;
  logic [13:0] lat_wdt;
  logic [13:0] lat_mem;
  logic [13:0] lat_code;
  logic        loaded;
  logic        sw_enable;
  logic [4:0]  period_rt;
  logic        period_sw_ok;
  logic        cfg_error;
  logic [13:0] user_id [4];
  logic        wr_acc;
  logic        rd_setup;
  logic        mapped;
  logic        cfg_wr_ok;
  logic [13:0] next_mem;
  logic [31:0] next_rdata;
  logic [15:0] bb_words;
  logic        in_boot;
  logic        in_sflash;
  logic        in_cfg;
  logic        in_app;
  logic        next_wdt_en;
  cwpd_pkg::cwpd_mode_e mode;

  // Boot block words from enable and size, clamped to half the memory
  function automatic logic [15:0] bb_decode(input logic en_n, input logic [2:0] sz);
    logic [15:0] w;
    logic [15:0] half;
    half = 16'(PM_WORDS / 2);
    if (en_n) begin
      w = 16'h0000;
    end else if (sz == 3'h7) begin
      w = `CWPD_BB_512;
    end else if (sz == 3'h6) begin
      w = `CWPD_BB_1024;
    end else begin
      w = `CWPD_BB_2048;
    end
    return (w > half) ? half : w;
  endfunction : bb_decode

  // Bus decode; answer is always zero-wait
  assign wr_acc   = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE;
  assign mapped   = (PADDR[1:0] == 2'h0) && (PADDR <= `CWPD_OFF_UID3);
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL && PENABLE && !mapped;
  assign cfg_wr_ok = mem_word[`CWPD_CFGWP_BIT];

  // Memory word merge: sticky bits only clear, size locked once boot enabled
  always_comb begin
    next_mem = (mem_word & PWDATA[13:0] & `CWPD_MEM_STICKY) | `CWPD_MEM_ONES;
    next_mem[`CWPD_LOWV_BIT] = LOWV_PROG_ACTIVE ? mem_word[`CWPD_LOWV_BIT]
                                                : PWDATA[`CWPD_LOWV_BIT];
    next_mem[2:0] = mem_word[`CWPD_BOOTEN_BIT] ? PWDATA[2:0] : mem_word[2:0];
  end

  // Nonvolatile words: reset leaves them alone so a programmed setup
  // survives it; only bulk erase restores them, winning over any write
  always_ff @(posedge REF_CLK) begin
    if (BULK_ERASE) begin
      wdt_word  <= `CWPD_ERASED;
      mem_word  <= `CWPD_ERASED;
      code_word <= `CWPD_ERASED;
    end else if (NRST && wr_acc && cfg_wr_ok) begin
      if (PADDR == `CWPD_OFF_WDT_CFG) begin
        wdt_word <= PWDATA[13:0] | `CWPD_WDT_ONES;
      end
      if (PADDR == `CWPD_OFF_MEM_CFG) begin
        mem_word <= next_mem;
      end
      if (PADDR == `CWPD_OFF_CODE_CFG) begin
        code_word <= {13'h1FFF, PWDATA[`CWPD_CODEP_BIT]};
      end
    end
  end

  // User ID words are plain storage, never protected
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < 4; i++) begin
        user_id[i] <= `CWPD_ERASED;
      end
    end else if (wr_acc && PADDR >= `CWPD_OFF_UID0 && PADDR <= `CWPD_OFF_UID3
                 && PADDR[1:0] == 2'h0) begin
      user_id[2'(PADDR[7:2] - 6'h05)] <= PWDATA[13:0];
    end
  end

  // Snapshot once after reset release; later writes wait for next reset
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      loaded  <= 1'b0;
      lat_wdt <= `CWPD_ERASED;
      lat_mem <= `CWPD_ERASED;
      lat_code <= `CWPD_ERASED;
    end else if (!loaded) begin
      loaded  <= 1'b1;
      lat_wdt <= wdt_word;
      lat_mem <= mem_word;
      lat_code <= code_word;
    end
  end

  // Runtime period: loaded from the snapshot, software may change it
  // only when the period field was erased
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      period_rt    <= `CWPD_PER_DEFAULT;
      period_sw_ok <= 1'b0;
      cfg_error    <= 1'b0;
    end else if (!loaded) begin
      period_sw_ok <= 1'b0;
      cfg_error    <= 1'b0;
      if (wdt_word[`CWPD_PER_HI:0] == `CWPD_PER_ERASED) begin
        period_rt    <= `CWPD_PER_DEFAULT;
        period_sw_ok <= 1'b1;
      end else if (wdt_word[`CWPD_PER_HI:0] <= `CWPD_PER_MAX) begin
        period_rt <= wdt_word[`CWPD_PER_HI:0];
      end else if (wdt_word[`CWPD_PER_HI:0] == `CWPD_PER_ALT32) begin
        period_rt <= 5'h00;
      end else begin
        period_rt <= `CWPD_PER_DEFAULT;
        cfg_error <= 1'b1;
      end
    end else if (wr_acc && PADDR == `CWPD_OFF_CTRL && period_sw_ok) begin
      period_rt <= (PWDATA[12:8] > `CWPD_PER_MAX) ? `CWPD_PER_DEFAULT : PWDATA[12:8];
    end
  end

  // Software watchdog enable
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      sw_enable <= 1'b0;
    end else if (wr_acc && PADDR == `CWPD_OFF_CTRL) begin
      sw_enable <= PWDATA[0];
    end
  end

  // Watchdog run decision; only the software mode looks at the enable bit
  assign mode = cwpd_pkg::cwpd_mode_e'(lat_wdt[`CWPD_MODE_HI:`CWPD_MODE_LO]);
  always_comb begin
    case (mode)
      cwpd_pkg::CWPD_WDT_ON:    next_wdt_en = 1'b1;
      cwpd_pkg::CWPD_WDT_AWAKE: next_wdt_en = !SLEEP;
      cwpd_pkg::CWPD_WDT_SOFT:  next_wdt_en = sw_enable;
      default:                  next_wdt_en = 1'b0;
    endcase
  end

  // Watchdog and reset pin outputs; only the enable is held off until the snapshot exists
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      WDT_ENABLE        <= 1'b0;
      WDT_DIV_EXP       <= 5'h00;
      WDT_CFG_ERROR     <= 1'b0;
      MCLR_PIN_IS_RESET <= 1'b1;
    end else begin
      WDT_ENABLE        <= loaded && next_wdt_en;
      WDT_DIV_EXP       <= period_rt + `CWPD_PER_BIAS;
      WDT_CFG_ERROR     <= cfg_error;
      MCLR_PIN_IS_RESET <= lat_mem[`CWPD_LOWV_BIT] || MCLR_ENABLE_CFG;
    end
  end

  // Region decode of a self-write target
  assign bb_words  = bb_decode(lat_mem[`CWPD_BOOTEN_BIT], lat_mem[2:0]);
  assign in_boot   = SELF_WR_ADDR < bb_words;
  assign in_sflash = !lat_mem[`CWPD_SFEN_BIT]
                     && SELF_WR_ADDR >= 16'(PM_WORDS - SFLASH_WORDS)
                     && SELF_WR_ADDR < 16'(PM_WORDS);
  assign in_cfg    = SELF_WR_ADDR >= `CWPD_CFG_LO && SELF_WR_ADDR <= `CWPD_CFG_HI;
  assign in_app    = SELF_WR_ADDR < 16'(PM_WORDS) && !in_boot && !in_sflash;

  // Per-region permission; addresses outside every region pass
  always_comb begin
    if (in_cfg) begin
      SELF_WR_OK = SELF_WR_REQ && lat_mem[`CWPD_CFGWP_BIT];
    end else if (in_boot) begin
      SELF_WR_OK = SELF_WR_REQ && lat_mem[`CWPD_BOOTWP_BIT];
    end else if (in_sflash) begin
      SELF_WR_OK = SELF_WR_REQ && lat_mem[`CWPD_SFWP_BIT];
    end else if (in_app) begin
      SELF_WR_OK = SELF_WR_REQ && lat_mem[`CWPD_APPWP_BIT];
    end else begin
      SELF_WR_OK = SELF_WR_REQ;
    end
  end

  // Read paths: CPU always sees data, external path masked by protection
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      CPU_RD_DATA      <= 14'h0000;
      EXT_RD_DATA      <= 14'h0000;
      EXT_ACCESS_BLOCK <= 1'b1;
      BOOT_BLOCK_WORDS <= 16'h0000;
    end else begin
      CPU_RD_DATA      <= PM_RD_DATA;
      EXT_RD_DATA      <= lat_code[`CWPD_CODEP_BIT] ? PM_RD_DATA : 14'h0000;
      EXT_ACCESS_BLOCK <= !lat_code[`CWPD_CODEP_BIT] || !loaded;
      BOOT_BLOCK_WORDS <= bb_words;
    end
  end

  // Read mux, captured in the setup cycle so data is ready in access
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (PADDR)
      `CWPD_OFF_WDT_CFG: next_rdata[13:0] = wdt_word;
      `CWPD_OFF_MEM_CFG: next_rdata[13:0] = mem_word;
      `CWPD_OFF_CODE_CFG: next_rdata[13:0] = code_word;
      `CWPD_OFF_CTRL:    next_rdata = {19'h0, period_rt, 7'h0, sw_enable};
      `CWPD_OFF_STATUS:  next_rdata = {bb_words, 7'h0, period_rt, period_sw_ok,
                                       cfg_error, loaded, next_wdt_en};
      default: begin
        if (PADDR >= `CWPD_OFF_UID0 && PADDR <= `CWPD_OFF_UID3 && PADDR[1:0] == 2'h0) begin
          next_rdata[13:0] = user_id[2'(PADDR[7:2] - 6'h05)];
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA <= next_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  property p_mode_off;
    loaded && mode == cwpd_pkg::CWPD_WDT_OFF |=> !WDT_ENABLE;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("wdt on in off mode");

  property p_mode_awake;
    loaded && mode == cwpd_pkg::CWPD_WDT_AWAKE && SLEEP |=> !WDT_ENABLE;
  endproperty
  a_mode_awake: assert property (p_mode_awake) else $error("wdt runs in sleep");

  property p_erased_period;
    !loaded && wdt_word[4:0] == 5'h1F |=> period_rt == 5'h0B && period_sw_ok
      ##1 WDT_DIV_EXP == 5'h10;
  endproperty
  a_erased_period: assert property (p_erased_period) else $error("bad default");

  property p_lowv_hold;
    LOWV_PROG_ACTIVE && mem_word[13] && !BULK_ERASE |=> mem_word[13];
  endproperty
  a_lowv_hold: assert property (p_lowv_hold) else $error("low-voltage bit cleared");

  property p_boot_block_size_lock;
    !mem_word[3] && !BULK_ERASE |=> $stable(mem_word[2:0]);
  endproperty
  a_boot_block_size_lock: assert property (p_boot_block_size_lock) else $error("size changed");

  property p_sticky;
    !BULK_ERASE |=> ((~$past(mem_word) & mem_word & 14'h0B98) == 14'h0000);
  endproperty
  a_sticky: assert property (p_sticky) else $error("protect bit set");

  property p_cfg_lock;
    !mem_word[9] && !BULK_ERASE |=> $stable(wdt_word) && $stable(code_word);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("cfg write passed");

  property p_code_read;
    loaded && !lat_code[0] |=> EXT_RD_DATA == 14'h0000 && EXT_ACCESS_BLOCK;
  endproperty
  a_code_read: assert property (p_code_read) else $error("ext read leaked");

  property p_ones;
    code_word[13:1] == 13'h1FFF && wdt_word[7] && mem_word[12] && mem_word[6:5] == 2'h3;
  endproperty
  a_ones: assert property (p_ones) else $error("unimplemented bit zero");

  property p_app_block;
    SELF_WR_REQ && in_app && !in_cfg && !lat_mem[7] |-> !SELF_WR_OK;
  endproperty
  a_app_block: assert property (p_app_block) else $error("app write passed");

endmodule : cwpd_top
`default_nettype wire

// ===== verif/cwpd_nvm_model.sv
// Program memory model that answers the decoder's read paths
`timescale 1ns/1ns
`default_nettype none
module cwpd_nvm_model (
  // Clock and read address
  input  wire logic        clk,
  input  wire logic [7:0]  addr,
  // Read word
  output logic [13:0]      data
);
  // Word tracks the address, so a stale copy downstream shows up at once
  always_ff @(posedge clk) begin
    data <= {addr[6:0], ~addr[6:0]};
  end
endmodule : cwpd_nvm_model
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the config word decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // Drives and observed outputs
  logic        clk, nrst, psel, pen, pwr, lowv_act, bulk, slp, mclr_en, swr, er;
  logic        pready, pslverr, wdt_en, wdt_err, mclr, swr_ok, ext_blk;
  logic [7:0]  paddr, pm_addr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  wdt_exp;
  logic [15:0] swr_addr, bb_words;
  logic [13:0] pm_data, cpu_data, ext_data;
  int          err_count, checked;

  // Block under test and memory partner
  cwpd_top dut (.REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
    .LOWV_PROG_ACTIVE(lowv_act), .BULK_ERASE(bulk), .SLEEP(slp), .MCLR_ENABLE_CFG(mclr_en),
    .WDT_ENABLE(wdt_en), .WDT_DIV_EXP(wdt_exp), .WDT_CFG_ERROR(wdt_err),
    .MCLR_PIN_IS_RESET(mclr), .SELF_WR_REQ(swr), .SELF_WR_ADDR(swr_addr),
    .SELF_WR_OK(swr_ok), .BOOT_BLOCK_WORDS(bb_words), .PM_RD_DATA(pm_data),
    .CPU_RD_DATA(cpu_data), .EXT_RD_DATA(ext_data), .EXT_ACCESS_BLOCK(ext_blk));
  cwpd_nvm_model nvm (.clk(clk), .addr(pm_addr), .data(pm_data));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits on ready, only the hang guard ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  // Read and compare
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic tdone(input string s);
    $display("test %s ended", s);
  endtask : tdone

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Post-reset decode of the erased words
  task automatic erased_outs;
    chk(wdt_en, 1'b1);
    chk(wdt_exp, 5'h10);
    chk(wdt_err, 1'b0);
    chk(mclr, 1'b1);
    chk(ext_blk, 1'b0);
    chk(bb_words, 16'h0);
  endtask : erased_outs

  // Hang guard, far beyond the run length
  initial begin
    #500000;
    err_count++;
    finish_test();
  end

  // Test sequence
  initial begin
    logic [4:0] pc [4];
    logic [4:0] pe [4];
    pc = '{5'h00, 5'h12, 5'h13, 5'h1E};
    pe = '{5'h00, 5'h12, 5'h0B, 5'h0B};
    {nrst, psel, pen, pwr, lowv_act, slp, mclr_en, swr} = '0;
    bulk = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    pm_addr = 8'h35;
    swr_addr = 16'h0;
    err_count = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    bulk <= 1'b0;
    repeat (3) @(posedge clk);
    #1 erased_outs();
    for (int i = 0; i < 3; i++) rchk(8'(4 * i), 32'h3FFF);
    for (int i = 5; i < 9; i++) rchk(8'(4 * i), 32'h3FFF);
    rchk(8'h10, 32'hBB);
    tdone("reset");
    // Sleep and master clear input do not move the erased decode
    @(posedge clk);
    slp   <= 1'b1;
    mclr_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(wdt_en, 1'b1);
    chk(mclr, 1'b1);
    tdone("sleep");
    // Runtime period is software-changeable, bad codes fall back
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h0C, {19'h0, pc[i], 8'h0});
      rchk(8'h10, {23'h0, pe[i], 4'hB});
    end
    tdone("period");
    // Writes land in the words but the decode stays latched
    apb(1'b1, 8'h00, 32'h0);
    rchk(8'h00, 32'h80);
    apb(1'b1, 8'h08, 32'h0);
    rchk(8'h08, 32'h3FFE);
    #1 chk(wdt_exp, 5'h10);
    chk(ext_blk, 1'b0);
    tdone("latch");
    // Protection word: sticky bits, locked size, low-voltage lock
    @(posedge clk);
    lowv_act <= 1'b1;
    apb(1'b1, 8'h04, 32'h0B1E);
    rchk(8'h04, 32'h3F7E);
    @(posedge clk);
    lowv_act <= 1'b0;
    apb(1'b1, 8'h04, 32'h3FFF);
    rchk(8'h04, 32'h3F7F);
    apb(1'b1, 8'h04, 32'h3FF7);
    apb(1'b1, 8'h04, 32'h3FFE);
    rchk(8'h04, 32'h3F77);
    apb(1'b1, 8'h04, 32'h1FFF);
    rchk(8'h04, 32'h1F77);
    apb(1'b1, 8'h04, 32'h3DFF);
    apb(1'b1, 8'h00, 32'h3FFF);
    rchk(8'h00, 32'h80);
    apb(1'b1, 8'h14, 32'hFFFF1234);
    rchk(8'h14, 32'h1234);
    tdone("protect");
    // Bulk erase restores every word, user IDs kept
    @(posedge clk);
    bulk <= 1'b1;
    repeat (2) @(posedge clk);
    bulk <= 1'b0;
    for (int i = 0; i < 3; i++) rchk(8'(4 * i), 32'h3FFF);
    rchk(8'h14, 32'h1234);
    tdone("erase");
    // Erased latch leaves the application area and addresses past the memory writable
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      swr      <= 1'b1;
      swr_addr <= 16'h0 + 16'(i) * 16'h2FFF;
      #2 chk(swr_ok, 1'b1);
      @(posedge clk);
      swr <= 1'b0;
      #2 chk(swr_ok, 1'b0);
    end
    tdone("selfwrite");
    // Both read paths pass the word one cycle late
    @(posedge clk);
    pm_addr <= 8'h5A;
    repeat (3) @(posedge clk);
    #1 chk(cpu_data, 14'h2D25);
    chk(ext_data, 14'h2D25);
    apb(1'b0, 8'h24, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    tdone("paths");
    // Programmed words survive reset and drive the decode
    apb(1'b1, 8'h00, 32'h14);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h04, 32'h0207);
    rchk(8'h04, 32'h1667);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(wdt_en, 1'b0);
    chk(wdt_err, 1'b1);
    chk(wdt_exp, 5'h10);
    chk(mclr, 1'b0);
    chk(ext_blk, 1'b1);
    chk(ext_data, 14'h0);
    chk(cpu_data, 14'h2D25);
    chk(bb_words, 16'h200);
    @(posedge clk);
    swr      <= 1'b1;
    swr_addr <= 16'h0100;
    #2 chk(swr_ok, 1'b0);
    @(posedge clk);
    swr_addr <= 16'h1F80;
    #2 chk(swr_ok, 1'b0);
    @(posedge clk);
    swr_addr <= 16'h1000;
    #2 chk(swr_ok, 1'b0);
    @(posedge clk);
    swr_addr <= 16'h8008;
    #2 chk(swr_ok, 1'b1);
    @(posedge clk);
    swr <= 1'b0;
    tdone("programmed");
    // Third reset in mid-run, together with bulk erase
    @(posedge clk);
    nrst <= 1'b0;
    bulk <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(ext_blk, 1'b1);
    chk(wdt_en, 1'b0);
    @(posedge clk);
    nrst <= 1'b1;
    bulk <= 1'b0;
    repeat (3) @(posedge clk);
    #1 erased_outs();
    tdone("rereset");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
